// ==== logic/rsi_pkg.sv ====
// Purpose: Shared constants for the register store decode and execute block
// Assumes: Instruction bytes arrive left aligned in a 24-bit word, byte 0 in bits 23-16
// Notes:   Selector values follow the single-word source field layout
package rsi_pkg;
	localparam int          INSTR_W      = 24;
	localparam int          WORD_W       = 16;
	localparam int          NUM_ACC      = 4;
	localparam int          NUM_TA       = 12;
	localparam int          NUM_CTRL     = 16;
	localparam int          NUM_RPT      = 5;
	// Single-word store: 1100 FSSS AAAA AAAI
	localparam logic [3:0]  OP_SW        = 4'hc;
	localparam int          SW_OP_POS    = 20;
	localparam int          SW_SEL_POS   = 16;
	// Paired store: 1011 AAAA AAAI FSSS 1100 xxxx
	localparam logic [3:0]  OP_PAIR      = 4'hb;
	localparam logic [3:0]  PAIR_SUFFIX  = 4'hc;
	localparam int          PAIR_SEL_POS = 8;
	localparam int          PAIR_SUF_POS = 4;
	// Control, byte and return-address stores: prefix, address, selector, suffix
	localparam logic [7:0]  OP_CTRL      = 8'he5;
	localparam logic [7:0]  OP_RETURN_ADDRESS_REG      = 8'heb;
	localparam int          PFX_POS      = 16;
	localparam int          SEL_POS      = 4;
	localparam int          SUF_POS      = 2;
	localparam logic [1:0]  SUF_CTRL     = 2'h2;
	localparam logic [1:0]  SUF_RPT      = 2'h3;
	localparam logic [1:0]  SUF_BYTE     = 2'h1;
	localparam logic [1:0]  SUF_RETURN_ADDRESS_REG     = 2'h1;
	localparam logic [3:0]  SEL_UNDEF_A  = 4'hd;
	localparam logic [3:0]  SEL_UNDEF_B  = 4'he;
	localparam logic [2:0]  RPT_SEL_MAX  = 3'h4;
	localparam logic [3:0]  TA_BASE      = 4'h4;
	localparam logic [3:0]  TA_LAST      = 4'hb;
	localparam logic [1:0]  BE_WORD      = 2'h3;
	localparam logic [1:0]  BE_HIGH      = 2'h2;
	localparam logic [1:0]  RPT_BLOCK_REPEAT_COUNT_0     = 2'h1;
	localparam logic [1:0]  RPT_BLOCK_REPEAT_COUNT_1     = 2'h2;
	// Timing in clock cycles
	localparam int          RETURN_ADDRESS_REG_CYCLES  = 5;
	localparam int          BRC_LATENCY  = 3;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_RETURN_ADDRESS_REG = 2'b10
	} rsi_state_e;
endpackage

// ==== logic/rsi_store_exec.sv ====
// Purpose: Decode and execute register store instructions onto the data write path
// Assumes: Operand address and its MEMORY_MAPPED_REGISTER flag are valid in the cycle the instruction is offered
// Notes:   Port 1 writes the addressed word, port 2 the word at address plus one
`timescale 1ns/1ps

// Overview of operation
// RQ1 - Two-byte store 1100, selector, address byte
// RQ2 - Accumulator store writes only bits 15-0
// RQ3 - Temp/aux store writes whole register directly
// RQ4 - Byte store: source 7-0 to word 15-8
// RQ5 - Byte store to MEMORY_MAPPED_REGISTER: no write, bus error
// RQ6 - Pair store: first register high, next low
// RQ7 - Program names only even pair first registers
// RQ8 - Long word: upper at address, lower at +1
// RQ9 - Prefix e5, suffix 10xx selects control register
// RQ10 - Suffix 11xx selects repeat and transition registers
// RQ11 - Prefix eb, 01xx: return-address store, five cycles
// RQ12 - Return address and context flags both stored
// RQ13 - Block repeat store waits three cycles after loop end
// RQ14 - Repeatable, no status bit read or written
// RQ15 - Flags high byte, address 23-16 low, then 15-0
module rsi_store_exec #(
	parameter int ADDR_W = 24
)(
	input  wire logic                      MCLK,
	input  wire logic                      NRST,
	input  wire logic                      INSTR_VALID,
	input  wire logic [23:0]               INSTR,
	input  wire logic [ADDR_W-1:0]         OPERAND_ADDR,
	input  wire logic                      OPERAND_IS_MMR,
	input  wire logic                      LOOP_END,
	input  wire logic [15:0]               ACC_REGS [4],
	input  wire logic [15:0]               TA_REGS [12],
	input  wire logic [15:0]               CTRL_REGS [16],
	input  wire logic [15:0]               RPT_REGS [5],
	input  wire logic [23:0]               RETURN_ADDRESS_REG,
	input  wire logic [7:0]                CONTROL_FLOW_CONTEXT,
	output logic                           READY,
	output logic                           WR_EN,
	output logic [ADDR_W-1:0]              WR_ADDR,
	output logic [15:0]                    WR_DATA,
	output logic [1:0]                     WR_BE,
	output logic                           WR2_EN,
	output logic [ADDR_W-1:0]              WR2_ADDR,
	output logic [15:0]                    WR2_DATA,
	output logic                           BUS_ERR_REQ,
	output logic                           ILLEGAL
);
	rsi_pkg::rsi_state_e state_r;
	rsi_pkg::rsi_state_e state_nxt;
	logic [1:0]          guard_r;
	logic [2:0]          cnt_r;
	logic [ADDR_W-1:0]   pend_addr_r;
	logic [2:0]          pend_sel_r;
	logic [31:0]         return_address_reg_word_r;
	logic [3:0]          sw_sel;
	logic [3:0]          sel;
	logic [3:0]          pair_sel;
	logic [3:0]          ta_idx;
	logic [3:0]          ta_nxt_idx;
	logic                take;
	logic                is_sw;
	logic                is_pair;
	logic                is_ctrl;
	logic                is_rpt;
	logic                is_byte;
	logic                is_return_address_reg;
	logic                is_brc;
	logic                brc_hold;
	logic                do_w1;
	logic                do_w2;
	logic [ADDR_W-1:0]   w1_addr;
	logic [15:0]         w1_data;
	logic [15:0]         w2_data;
	logic [1:0]          w1_be;
	logic [15:0]         sw_src;
	logic                wr_brc_r;

	////////////////////////////////////////////////////////////////////////////
	// Decode

	assign take     = INSTR_VALID && (state_r == rsi_pkg::ST_IDLE);
	assign sw_sel   = INSTR[rsi_pkg::SW_SEL_POS +: 4];
	assign sel      = INSTR[rsi_pkg::SEL_POS +: 4];
	assign pair_sel = INSTR[rsi_pkg::PAIR_SEL_POS +: 4];
	assign is_sw    = take && (INSTR[rsi_pkg::SW_OP_POS +: 4] == rsi_pkg::OP_SW); // RQ1
	assign is_pair  = take && (INSTR[rsi_pkg::SW_OP_POS +: 4] == rsi_pkg::OP_PAIR)
		&& (INSTR[rsi_pkg::PAIR_SUF_POS +: 4] == rsi_pkg::PAIR_SUFFIX);
	assign is_ctrl  = take && (INSTR[rsi_pkg::PFX_POS +: 8] == rsi_pkg::OP_CTRL)
		&& (INSTR[rsi_pkg::SUF_POS +: 2] == rsi_pkg::SUF_CTRL)
		&& (sel != rsi_pkg::SEL_UNDEF_A) && (sel != rsi_pkg::SEL_UNDEF_B); // RQ9
	assign is_rpt   = take && (INSTR[rsi_pkg::PFX_POS +: 8] == rsi_pkg::OP_CTRL)
		&& (INSTR[rsi_pkg::SUF_POS +: 2] == rsi_pkg::SUF_RPT) && (sel[2:0] <= rsi_pkg::RPT_SEL_MAX); // RQ10
	assign is_byte  = take && (INSTR[rsi_pkg::PFX_POS +: 8] == rsi_pkg::OP_CTRL)
		&& (INSTR[rsi_pkg::SUF_POS +: 2] == rsi_pkg::SUF_BYTE) && !INSTR[0];
	assign is_return_address_reg  = take && (INSTR[rsi_pkg::PFX_POS +: 8] == rsi_pkg::OP_RETURN_ADDRESS_REG)
		&& (INSTR[rsi_pkg::SUF_POS +: 2] == rsi_pkg::SUF_RETURN_ADDRESS_REG); // RQ11
	assign is_brc   = is_rpt && ((sel[1:0] == rsi_pkg::RPT_BLOCK_REPEAT_COUNT_0) || (sel[1:0] == rsi_pkg::RPT_BLOCK_REPEAT_COUNT_1))
		&& !sel[2];
	assign brc_hold = LOOP_END || (guard_r != 2'h0); // RQ13

	// Pair partner is the next-numbered register (index 11 pairs with itself); odd first registers are the program's fault
	assign ta_idx     = pair_sel - rsi_pkg::TA_BASE; // RQ7
	assign ta_nxt_idx = (ta_idx == rsi_pkg::TA_LAST) ? ta_idx : ta_idx + 4'h1;
	// Dedicated paths: no ALU, shifter or multiplier in the way
	assign sw_src = sw_sel[3:2] == 2'h0 ? ACC_REGS[sw_sel[1:0]] : TA_REGS[sw_sel - rsi_pkg::TA_BASE]; // RQ2 RQ3

	////////////////////////////////////////////////////////////////////////////
	// Write selection; no status bit is read or modified anywhere

	always_comb begin
		do_w1   = 1'b0;
		do_w2   = 1'b0;
		w1_addr = OPERAND_ADDR;
		w1_data = 16'h0000;
		w2_data = 16'h0000;
		w1_be   = rsi_pkg::BE_WORD;
		if (state_r == rsi_pkg::ST_RETURN_ADDRESS_REG && cnt_r == 3'h0) begin
			do_w1   = 1'b1;
			do_w2   = 1'b1;
			w1_addr = pend_addr_r;
			w1_data = return_address_reg_word_r[31:16]; // RQ12
			w2_data = return_address_reg_word_r[15:0]; // RQ12
		end else if (state_r == rsi_pkg::ST_WAIT && !brc_hold) begin
			do_w1   = 1'b1;
			w1_addr = pend_addr_r;
			w1_data = RPT_REGS[pend_sel_r];
		end else if (is_sw) begin
			do_w1   = 1'b1;
			w1_data = sw_src; // RQ2 RQ3
		end else if (is_byte && !OPERAND_IS_MMR) begin
			do_w1   = 1'b1;
			w1_be   = rsi_pkg::BE_HIGH;
			w1_data = {(sw_src_byte(sel)), 8'h00}; // RQ4
		end else if (is_pair) begin
			do_w1   = 1'b1;
			do_w2   = 1'b1;
			w1_data = TA_REGS[ta_idx]; // RQ6
			w2_data = TA_REGS[ta_nxt_idx]; // RQ6
		end else if (is_ctrl) begin
			do_w1   = 1'b1;
			w1_data = CTRL_REGS[sel]; // RQ9
		end else if (is_rpt && !(is_brc && brc_hold)) begin
			do_w1   = 1'b1;
			w1_data = RPT_REGS[sel[2:0]]; // RQ10
		end
	end

	function automatic logic [7:0] sw_src_byte(input logic [3:0] s);
		logic [15:0] v;
		v = (s[3:2] == 2'h0) ? ACC_REGS[s[1:0]] : TA_REGS[s - rsi_pkg::TA_BASE];
		return v[7:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Sequencing

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			rsi_pkg::ST_IDLE: begin
				if (is_return_address_reg)
					state_nxt = rsi_pkg::ST_RETURN_ADDRESS_REG; // RQ11
				else if (is_brc && brc_hold)
					state_nxt = rsi_pkg::ST_WAIT; // RQ13
			end
			rsi_pkg::ST_WAIT: begin
				if (!brc_hold)
					state_nxt = rsi_pkg::ST_IDLE;
			end
			rsi_pkg::ST_RETURN_ADDRESS_REG: begin
				if (cnt_r == 3'h0)
					state_nxt = rsi_pkg::ST_IDLE;
			end
			default: state_nxt = rsi_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			state_r <= rsi_pkg::ST_IDLE;
			READY   <= 1'b1;
		end else begin
			state_r <= state_nxt;
			READY   <= (state_nxt == rsi_pkg::ST_IDLE); // RQ14
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST)
			guard_r <= 2'h0;
		else if (LOOP_END)
			guard_r <= 2'(rsi_pkg::BRC_LATENCY - 1); // RQ13
		else if (guard_r != 2'h0)
			guard_r <= guard_r - 2'h1;
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			cnt_r       <= 3'h0;
			pend_addr_r <= '0;
			pend_sel_r  <= 3'h0;
			return_address_reg_word_r <= 32'h0000_0000;
		end else if (is_return_address_reg) begin
			cnt_r       <= 3'(rsi_pkg::RETURN_ADDRESS_REG_CYCLES - 2); // RQ11
			pend_addr_r <= OPERAND_ADDR;
			return_address_reg_word_r <= {CONTROL_FLOW_CONTEXT, RETURN_ADDRESS_REG}; // RQ15
		end else if (is_brc) begin
			pend_addr_r <= OPERAND_ADDR;
			pend_sel_r  <= sel[2:0];
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write ports and error request

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			WR_EN    <= 1'b0;
			WR_ADDR  <= '0;
			WR_DATA  <= 16'h0000;
			WR_BE    <= 2'h0;
			WR2_EN   <= 1'b0;
			WR2_ADDR <= '0;
			WR2_DATA <= 16'h0000;
			wr_brc_r <= 1'b0;
		end else begin
			WR_EN    <= do_w1;
			WR_ADDR  <= w1_addr;
			WR_DATA  <= w1_data;
			WR_BE    <= do_w1 ? w1_be : 2'h0;
			WR2_EN   <= do_w2;
			WR2_ADDR <= w1_addr + ADDR_W'(1); // RQ8
			WR2_DATA <= w2_data;
			wr_brc_r <= do_w1 && ((state_r == rsi_pkg::ST_WAIT) || is_brc);
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			BUS_ERR_REQ <= 1'b0;
			ILLEGAL     <= 1'b0;
		end else begin
			BUS_ERR_REQ <= is_byte && OPERAND_IS_MMR; // RQ5
			ILLEGAL     <= take && !(is_sw || is_pair || is_ctrl || is_rpt || is_byte || is_return_address_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!NRST);

	sequence return_address_reg_busy_s;
		(!READY && !WR_EN && !WR2_EN) [*4];
	endsequence
	sequence return_address_reg_done_s;
		WR_EN && WR2_EN && READY;
	endsequence

	sw_store_a: assert property (is_sw |=> WR_EN && !WR2_EN && WR_BE == 2'h3 // RQ1
		&& WR_ADDR == $past(OPERAND_ADDR)) else $error("single-word store missing");
	acc_low_a: assert property (is_sw && sw_sel < 4'h4 |=> WR_DATA == $past(ACC_REGS[sw_sel[1:0]])) // RQ2
		else $error("accumulator low word wrong");
	ta_full_a: assert property (is_sw && sw_sel == 4'h8 |=> WR_DATA == $past(TA_REGS[4])) // RQ3
		else $error("aux register word wrong");
	high_byte_a: assert property (is_byte && !OPERAND_IS_MMR |=> WR_BE == 2'h2 // RQ4
		&& WR_DATA[15:8] == $past(sw_src_byte(sel))) else $error("byte store wrong");
	byte_mmr_a: assert property (is_byte && OPERAND_IS_MMR |=> BUS_ERR_REQ && !WR_EN) // RQ5
		else $error("byte store to mapped register not refused");
	pair_order_a: assert property (is_pair |=> WR2_EN && WR2_ADDR == WR_ADDR + ADDR_W'(1) // RQ8
		&& WR_DATA == $past(TA_REGS[ta_idx])) else $error("pair store wrong");
	return_address_reg_time_a: assert property (is_return_address_reg |=> return_address_reg_busy_s ##1 return_address_reg_done_s) // RQ11
		else $error("return-address store timing wrong");
	return_address_reg_data_a: assert property (is_return_address_reg |-> ##5 WR_DATA == {$past(CONTROL_FLOW_CONTEXT, 5), // RQ15
		$past(RETURN_ADDRESS_REG[23:16], 5)} && WR2_DATA == $past(RETURN_ADDRESS_REG[15:0], 5))
		else $error("return-address layout wrong");
	brc_gap_a: assert property (LOOP_END |=> !wr_brc_r [*3]) // RQ13
		else $error("repeat counter stored too early");
	repeat_a: assert property (is_sw |=> READY) // RQ14
		else $error("single-word store not repeatable");
endmodule

// ==== test/rsi_mem_model.sv ====
// Purpose: Data memory behind the store write path
// Assumes: Low 8 address bits decoded, word addressed
// Notes:   Byte enables pick the halves of a word
`timescale 1ns/1ps
module rsi_mem_model (
	input  wire logic        clk,
	input  wire logic        wr_en,
	input  wire logic [23:0] wr_addr,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0]  wr_be,
	input  wire logic        wr2_en,
	input  wire logic [23:0] wr2_addr,
	input  wire logic [15:0] wr2_data,
	input  wire logic [7:0]  rd_addr,
	output logic      [15:0] rd_data
);
	logic [15:0] mem_r [256];
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem_r[i] = {8'(i), 8'(~i)};
		end
	end
	always @(posedge clk) begin
		if (wr_en && wr_be[1]) begin
			mem_r[wr_addr[7:0]][15:8] <= wr_data[15:8];
		end
		if (wr_en && wr_be[0]) begin
			mem_r[wr_addr[7:0]][7:0] <= wr_data[7:0];
		end
		if (wr2_en) begin
			mem_r[wr2_addr[7:0]] <= wr2_data;
		end
	end
	assign rd_data = mem_r[rd_addr];
endmodule

// ==== test/rsi_store_exec_tb.sv ====
// Purpose: Self-checking bench for the register store block
// Assumes: One instruction in flight at a time
// Notes:   cyc counts edges from the take edge to the outcome
`timescale 1ns/1ps
module rsi_store_exec_tb;
	logic        MCLK = 0, NRST = 0, INSTR_VALID = 0, OPERAND_IS_MMR = 0, LOOP_END = 0;
	logic [23:0] INSTR = '0, OPERAND_ADDR = '0, RETURN_ADDRESS_REG = 24'h5a6b7c;
	logic [7:0]  CONTROL_FLOW_CONTEXT = 8'h3d, rd_a = '0;
	logic [15:0] ACC_REGS [4], TA_REGS [12], CTRL_REGS [16], RPT_REGS [5];
	logic        READY, WR_EN, WR2_EN, BUS_ERR_REQ, ILLEGAL;
	logic [23:0] WR_ADDR, WR2_ADDR;
	logic [15:0] WR_DATA, WR2_DATA, mem_q;
	logic [1:0]  WR_BE;
	int          fail_count = 0, checks = 0, cyc, lo;

	always #25 MCLK = ~MCLK;

	rsi_store_exec u_dut (.MCLK(MCLK), .NRST(NRST), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
		.OPERAND_ADDR(OPERAND_ADDR), .OPERAND_IS_MMR(OPERAND_IS_MMR), .LOOP_END(LOOP_END),
		.ACC_REGS(ACC_REGS), .TA_REGS(TA_REGS), .CTRL_REGS(CTRL_REGS), .RPT_REGS(RPT_REGS),
		.RETURN_ADDRESS_REG(RETURN_ADDRESS_REG), .CONTROL_FLOW_CONTEXT(CONTROL_FLOW_CONTEXT),
		.READY(READY), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .WR_BE(WR_BE),
		.WR2_EN(WR2_EN), .WR2_ADDR(WR2_ADDR), .WR2_DATA(WR2_DATA), .BUS_ERR_REQ(BUS_ERR_REQ),
		.ILLEGAL(ILLEGAL));

	rsi_mem_model u_mem (.clk(MCLK), .wr_en(WR_EN), .wr_addr(WR_ADDR), .wr_data(WR_DATA),
		.wr_be(WR_BE), .wr2_en(WR2_EN), .wr2_addr(WR2_ADDR), .wr2_data(WR2_DATA),
		.rd_addr(rd_a), .rd_data(mem_q));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic issue(input logic [23:0] ins, input logic [23:0] adr, input logic memory_mapped_register, input logic lend);
		@(posedge MCLK);
		INSTR_VALID    <= 1'b1;
		INSTR          <= ins;
		OPERAND_ADDR   <= adr;
		OPERAND_IS_MMR <= memory_mapped_register;
		LOOP_END       <= lend;
		@(posedge MCLK);
		INSTR_VALID <= 1'b0;
		LOOP_END    <= 1'b0;
		cyc = 0;
		lo  = 0;
		#1;
		while (!(WR_EN === 1'b1 || BUS_ERR_REQ === 1'b1 || ILLEGAL === 1'b1)) begin
			if (READY === 1'b0) begin
				lo++;
			end
			if (cyc == 8) begin
				fail_count++;
				tally_and_finish();
			end
			@(posedge MCLK);
			#1;
			cyc++;
		end
	endtask

	function automatic logic [15:0] srcv(input int s);
		return (s < 4) ? ACC_REGS[s] : TA_REGS[s-4];
	endfunction

	task automatic mem_chk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge MCLK);
		#1;
		rd_a = a;
		#1;
		chk(mem_q, exp);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic sc_single();
		for (int s = 0; s < 16; s++) begin
			issue({4'hc, 4'(s), 8'h10, 8'h00}, 24'h000100 + 24'(s), 1'b0, 1'b0);
			chk(32'(cyc), 32'h0);
			chk(READY, 1'b1);
			chk(WR_DATA, srcv(s));
			chk({WR_BE, WR2_EN, WR_ADDR}, {2'h3, 1'b0, 24'h000100 + 24'(s)});
		end
	endtask

	task automatic sc_byte();
		for (int s = 0; s < 16; s += 5) begin
			issue({8'he5, 8'h20, 4'(s), 4'h4}, 24'h000020 + 24'(s), 1'b0, 1'b0);
			chk(WR_BE, 2'h2);
			mem_chk(8'h20 + 8'(s), {8'(srcv(s)), ~(8'h20 + 8'(s))});
		end
		issue({8'he5, 8'h30, 4'h4, 4'h4}, 24'h000030, 1'b1, 1'b0);
		chk({BUS_ERR_REQ, WR_EN}, 2'b10);
		mem_chk(8'h30, 16'h30cf);
	endtask

	task automatic sc_pair();
		for (int s = 4; s < 16; s += 2) begin
			issue({4'hb, 8'h60, 4'(s), 4'hc, 4'h0}, 24'h000060 + 24'(s), 1'b0, 1'b0);
			chk({WR_DATA, WR2_DATA}, {TA_REGS[s-4], TA_REGS[s-3]});
			chk({WR2_EN, WR2_ADDR}, {1'b1, 24'h000061 + 24'(s)});
			chk(WR_ADDR, 24'h000060 + 24'(s));
		end
	endtask

	task automatic sc_ctrl();
		for (int s = 0; s < 16; s++) begin
			issue({8'he5, 8'h80, 4'(s), 2'h2, 2'h0}, 24'h000080, 1'b0, 1'b0);
			if (s == 13 || s == 14) begin
				chk({ILLEGAL, WR_EN}, 2'b10);
			end else begin
				chk({WR_EN, WR_DATA}, {1'b1, CTRL_REGS[s]});
			end
		end
		// Top selector bit toggled to show it is ignored
		for (int s = 0; s < 8; s++) begin
			issue({8'he5, 8'h80, 1'(s), 3'(s), 2'h3, 2'h0}, 24'h000080, 1'b0, 1'b0);
			if (s > 4) begin
				chk({ILLEGAL, WR_EN}, 2'b10);
			end else begin
				chk({WR_EN, WR_DATA}, {1'b1, RPT_REGS[s]});
			end
		end
	endtask

	task automatic sc_return_address_reg_loop();
		issue({8'heb, 8'h90, 4'h0, 2'h1, 2'h0}, 24'h000090, 1'b0, 1'b0);
		chk(32'(cyc), 32'h4);
		chk(32'(lo), 32'h4);
		chk(WR_ADDR, 24'h000090);
		chk({WR_DATA, WR2_DATA}, {CONTROL_FLOW_CONTEXT, RETURN_ADDRESS_REG});
		chk({WR2_EN, WR2_ADDR}, {1'b1, 24'h000091});
		issue({8'he5, 8'h80, 4'h2, 2'h3, 2'h0}, 24'h000080, 1'b0, 1'b1);
		chk(32'(cyc), 32'h3);
		chk(32'(lo), 32'h3);
		chk(WR_DATA, RPT_REGS[2]);
		issue({8'he5, 8'h80, 4'h0, 2'h3, 2'h0}, 24'h000080, 1'b0, 1'b1);
		chk(32'(cyc), 32'h0);
		chk({WR_EN, WR_DATA}, {1'b1, RPT_REGS[0]});
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 16; i++) begin
			CTRL_REGS[i] = 16'hc000 + 16'(i * 273);
			if (i < 4) ACC_REGS[i] = 16'ha0f0 + 16'(i);
			if (i < 12) TA_REGS[i] = 16'h7e00 + 16'(i * 259);
			if (i < 5) RPT_REGS[i] = 16'h3490 + 16'(i * 17);
		end
		@(posedge MCLK);
		#1;
		chk({READY, WR_EN, WR2_EN, BUS_ERR_REQ, ILLEGAL}, 5'b10000);
		@(posedge MCLK);
		NRST <= 1'b1;
		sc_single();
		sc_byte();
		sc_pair();
		sc_ctrl();
		sc_return_address_reg_loop();
		tally_and_finish();
	end
endmodule
